// ===== core/port_regs_pkg.sv
// Constants, field layouts and carrier types for the per-port status/capability registers.
// Assumes a single core clock and a plain strobe-based register port.
// Functional notes
// - Error flags 16..19 latch regardless of reporting enables; cleared only by writing one.
// - Correctable error sets status bit 16; resets to zero.
// - Non-fatal error sets status bit 17; resets to zero.
// - Fatal error sets status bit 18; resets to zero.
// - Unsupported request sets status bit 19; resets to zero.
// - Status bit 20 reports auxiliary power present; resets to one.
// - Transactions-pending bit 21 always reads zero.
// - Max link speed bits 3:0 read-only, reset to 5 Gb/s code.
// - Max link width bits 9:4 read-only, reset to single lane.
// - Power management support bits 11:10 read-only, reset to zero.
// - L0s exit latency bits 14:12 reset to the 256-512 ns code.
// - L1 exit latency bits 17:15 reset to the all-zero code.
// - Upstream port fixes link-active reporting bit 20 at zero.
// - Hot-plug or link-active reporting downstream port reads bit 20 as one.
// - Bandwidth notify bit 21 is zero upstream, one downstream.
// - Port number bits 31:24 reset to the port index.
// - Speed, power, latency and port-number defaults overridable by sideband load.
package port_regs_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_DEVICE_STATUS = 8'hC8;
   localparam logic [7:0] OFS_LINK_CAPABILITIES = 8'hCC;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'hE0;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hE4;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'hE8;
   localparam int ERR_LSB = 16;
   localparam int AUX_BIT = 20;
   localparam int PEND_BIT = 21;
   localparam int SPEED_LSB = 0;
   localparam int WIDTH_LSB = 4;
   localparam int ASPM_LSB = 10;
   localparam int L0S_LSB = 12;
   localparam int L1_LSB = 15;
   localparam int DLL_BIT = 20;
   localparam int BWN_BIT = 21;
   localparam int PORT_LSB = 24;
   localparam logic [3:0] RST_SPEED = 4'h2;
   localparam logic [5:0] RST_WIDTH = 6'h01;
   localparam logic [1:0] RST_ASPM = 2'h0;
   localparam logic [2:0] RST_L0S = 3'h3;
   localparam logic [2:0] RST_L1 = 3'h0;
   localparam logic RST_AUX = 1'b1;
   localparam logic PEND_VAL = 1'b0;
   localparam int NUM_ERR = 4;

   // Error classes in status bit order
   typedef struct packed {
      logic unsup_req;
      logic fatal;
      logic non_fatal;
      logic correctable;
   } err_vec_s;

   // Sideband override of capability defaults
   typedef struct packed {
      logic [7:0] port_num;
      logic [2:0] l1_lat;
      logic [2:0] l0s_lat;
      logic [1:0] aspm;
      logic [3:0] speed;
   } cap_load_s;
endpackage

// ===== core/port_devstat_linkcap_regs.sv
// Device status and link capability registers of one switch port, with error interrupt.
// Assumes error pulses and sideband loads arrive on i_ref_clk from on-chip logic.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module port_devstat_linkcap_regs #(
   parameter logic [7:0] PORT_INDEX = 8'h00,
   parameter bit IS_UPSTREAM = 1'b1,
   parameter bit DL_ACTIVE_REPORT = 1'b0,
   parameter bit HOT_PLUG_CAPABLE = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [port_regs_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire port_regs_pkg::err_vec_s i_err,
   input wire logic i_cap_load,
   input wire port_regs_pkg::cap_load_s i_cap_data,
   output logic o_irq
);
   // Refused at elaboration so a bad option never reaches silicon
   if (IS_UPSTREAM && (DL_ACTIVE_REPORT || HOT_PLUG_CAPABLE)) begin : g_bad_upstream
      $error("Upstream port cannot report link-active state");
   end
   if (PORT_INDEX > 8'h02) begin : g_bad_index
      $error("Port index must be 0, 1 or 2");
   end

   port_regs_pkg::err_vec_s err_ff;
   port_regs_pkg::err_vec_s irq_en_ff;
   port_regs_pkg::cap_load_s cap_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   port_regs_pkg::err_vec_s clr_w1c;
   port_regs_pkg::err_vec_s clr_irq;
   logic dll_bit;
   logic bwn_bit;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Upstream forces zero regardless of the options
   assign dll_bit = !IS_UPSTREAM && (DL_ACTIVE_REPORT || HOT_PLUG_CAPABLE);
   assign bwn_bit = !IS_UPSTREAM;

   assign clr_w1c = (i_wr && hit(i_addr, port_regs_pkg::OFS_DEVICE_STATUS)) ?
      i_wdata[port_regs_pkg::ERR_LSB +: port_regs_pkg::NUM_ERR] : '0;
   assign clr_irq = (i_wr && hit(i_addr, port_regs_pkg::OFS_IRQ_CLEAR)) ?
      i_wdata[port_regs_pkg::NUM_ERR-1:0] : '0;

   // Set beats clear; enables play no part in logging
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn)
         err_ff <= '0;
      else
         err_ff <= i_err | (err_ff & ~(clr_w1c | clr_irq));
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn)
         irq_en_ff <= '0;
      else if (i_wr && hit(i_addr, port_regs_pkg::OFS_IRQ_ENABLE))
         irq_en_ff <= i_wdata[port_regs_pkg::NUM_ERR-1:0];
   end

   // Software cannot write capabilities; only the sideband loader can
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         cap_ff.speed <= port_regs_pkg::RST_SPEED;
         cap_ff.aspm <= port_regs_pkg::RST_ASPM;
         cap_ff.l0s_lat <= port_regs_pkg::RST_L0S;
         cap_ff.l1_lat <= port_regs_pkg::RST_L1;
         cap_ff.port_num <= PORT_INDEX;
      end else if (i_cap_load) begin
         cap_ff <= i_cap_data;
      end
   end

   always_comb begin
      nxt_rdata = '0;
      if (hit(i_addr, port_regs_pkg::OFS_DEVICE_STATUS)) begin
         nxt_rdata[port_regs_pkg::ERR_LSB +: port_regs_pkg::NUM_ERR] = err_ff;
         nxt_rdata[port_regs_pkg::AUX_BIT] = port_regs_pkg::RST_AUX;
         nxt_rdata[port_regs_pkg::PEND_BIT] = port_regs_pkg::PEND_VAL;
      end else if (hit(i_addr, port_regs_pkg::OFS_LINK_CAPABILITIES)) begin
         nxt_rdata[port_regs_pkg::SPEED_LSB +: 4] = cap_ff.speed;
         nxt_rdata[port_regs_pkg::WIDTH_LSB +: 6] = port_regs_pkg::RST_WIDTH;
         nxt_rdata[port_regs_pkg::ASPM_LSB +: 2] = cap_ff.aspm;
         nxt_rdata[port_regs_pkg::L0S_LSB +: 3] = cap_ff.l0s_lat;
         nxt_rdata[port_regs_pkg::L1_LSB +: 3] = cap_ff.l1_lat;
         nxt_rdata[port_regs_pkg::DLL_BIT] = dll_bit;
         nxt_rdata[port_regs_pkg::BWN_BIT] = bwn_bit;
         nxt_rdata[port_regs_pkg::PORT_LSB +: 8] = cap_ff.port_num;
      end else if (hit(i_addr, port_regs_pkg::OFS_IRQ_ENABLE)) begin
         nxt_rdata[port_regs_pkg::NUM_ERR-1:0] = irq_en_ff;
      end else if (hit(i_addr, port_regs_pkg::OFS_IRQ_STATUS)) begin
         nxt_rdata[port_regs_pkg::NUM_ERR-1:0] = err_ff;
      end
   end

   // Data valid only in the cycle after the read strobe
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn)
         rdata_ff <= '0;
      else if (i_rd)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= '0;
   end

   assign o_rdata = rdata_ff;
   assign o_irq = |(err_ff & irq_en_ff);

   sequence err_seen_s;
      i_err.fatal;
   endsequence

   property flag_holds_p;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      err_seen_s |=> err_ff.fatal;
   endproperty

   err_latch_a: assert property (flag_holds_p)
      else $error("fatal flag not latched");

   set_wins_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_err.correctable && clr_w1c.correctable) |=> err_ff.correctable)
      else $error("clear beat a simultaneous error");

   sticky_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (err_ff.non_fatal && !clr_w1c.non_fatal && !clr_irq.non_fatal) |=> err_ff.non_fatal)
      else $error("flag dropped without a clear");

   w1c_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (clr_w1c.unsup_req && !i_err.unsup_req) |=> !err_ff.unsup_req)
      else $error("write one did not clear flag");

   aux_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_rd && hit(i_addr, port_regs_pkg::OFS_DEVICE_STATUS)) |=>
      (o_rdata[port_regs_pkg::AUX_BIT] && !o_rdata[port_regs_pkg::PEND_BIT]
       && o_rdata[31:22] == 10'h000))
      else $error("status fixed bits wrong");

   cap_fixed_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_rd && hit(i_addr, port_regs_pkg::OFS_LINK_CAPABILITIES)) |=>
      (o_rdata[9:4] == 6'h01 && o_rdata[23:22] == 2'h0 && o_rdata[19:18] == 2'h0
       && o_rdata[21] == !IS_UPSTREAM))
      else $error("capability fixed fields wrong");

   link_active_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_rd && hit(i_addr, port_regs_pkg::OFS_LINK_CAPABILITIES) && IS_UPSTREAM) |=>
      !o_rdata[20])
      else $error("upstream link-active bit set");

   cap_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      i_cap_load |=> (cap_ff == $past(i_cap_data)))
      else $error("sideband load not taken");

   rd_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      !$past(i_rd) |-> (o_rdata == 32'h0000_0000))
      else $error("read data outside its cycle");

   // Enabled error with no register write in flight must raise the line next cycle
   irq_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ((|(i_err & irq_en_ff)) && !i_wr) |=> o_irq)
      else $error("interrupt not raised by enabled error");

   // Every error class latches its own flag
   for (genvar gi = 0; gi < port_regs_pkg::NUM_ERR; gi++) begin : g_err_chk
      flag_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
         i_err[gi] |=> err_ff[gi])
         else $error("error flag not set");
   end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the port status/capability register block.
// Assumes a downstream hot-plug port 2; the bench drives every port itself.
`timescale 1ns/1ps
module tb;
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   port_regs_pkg::err_vec_s i_err = '0;
   logic i_cap_load = 1'b0;
   port_regs_pkg::cap_load_s i_cap_data = '0;
   logic o_irq;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   localparam logic [31:0] ST_IDLE = 32'h0010_0000;
   port_devstat_linkcap_regs #(.PORT_INDEX(8'h02), .IS_UPSTREAM(1'b0),
      .DL_ACTIVE_REPORT(1'b0), .HOT_PLUG_CAPABLE(1'b1)) uut (.i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_err(i_err), .i_cap_load(i_cap_load), .i_cap_data(i_cap_data),
      .o_irq(o_irq));
   initial begin
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard: the whole run needs well under 300 cycles
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk(name, exp, o_rdata);
   endtask
   task automatic pulse_err(input logic [3:0] v);
      @(posedge i_ref_clk);
      i_err <= v;
      @(posedge i_ref_clk);
      i_err <= '0;
   endtask
   task automatic t_reset_values();
      bus_rd("status_rst", port_regs_pkg::OFS_DEVICE_STATUS, ST_IDLE);
      bus_rd("caps_rst", port_regs_pkg::OFS_LINK_CAPABILITIES, 32'h0230_3012);
      bus_rd("unmapped", 8'h00, 32'h0);
      bus_wr(port_regs_pkg::OFS_LINK_CAPABILITIES, 32'hFFFF_FFFF);
      bus_wr(port_regs_pkg::OFS_DEVICE_STATUS, 32'hFFC0_FFFF);
      bus_rd("caps_ro", port_regs_pkg::OFS_LINK_CAPABILITIES, 32'h0230_3012);
      bus_rd("status_rsvd", port_regs_pkg::OFS_DEVICE_STATUS, ST_IDLE);
   endtask
   task automatic t_error_flags();
      logic [31:0] f;
      for (int i = 0; i < 4; i++) begin
         f = 32'h0001_0000 << i;
         pulse_err(4'h1 << i);
         bus_wr(port_regs_pkg::OFS_DEVICE_STATUS, ~f & 32'h000F_0000);
         bus_rd("flag_set", port_regs_pkg::OFS_DEVICE_STATUS, ST_IDLE | f);
         chk("irq_masked", 32'h0, {31'h0, o_irq});
         bus_wr(port_regs_pkg::OFS_DEVICE_STATUS, f);
         bus_rd("flag_clr", port_regs_pkg::OFS_DEVICE_STATUS, ST_IDLE);
      end
   endtask
   task automatic t_set_beats_clear();
      @(posedge i_ref_clk);
      i_err <= 4'h4;
      i_wr <= 1'b1;
      i_addr <= port_regs_pkg::OFS_DEVICE_STATUS;
      i_wdata <= 32'h0004_0000;
      @(posedge i_ref_clk);
      i_err <= '0;
      i_wr <= 1'b0;
      bus_rd("set_wins", port_regs_pkg::OFS_DEVICE_STATUS, 32'h0014_0000);
      bus_wr(port_regs_pkg::OFS_DEVICE_STATUS, 32'h0004_0000);
   endtask
   task automatic t_interrupt();
      bus_wr(port_regs_pkg::OFS_IRQ_ENABLE, 32'h0000_0008);
      pulse_err(4'h9);
      #1 chk("irq_on", 32'h1, {31'h0, o_irq});
      bus_rd("irq_stat", port_regs_pkg::OFS_IRQ_STATUS, 32'h0000_0009);
      bus_wr(port_regs_pkg::OFS_IRQ_CLEAR, 32'h0000_0008);
      #1 chk("irq_off", 32'h0, {31'h0, o_irq});
      bus_rd("after_clr", port_regs_pkg::OFS_DEVICE_STATUS, 32'h0011_0000);
   endtask
   task automatic t_cap_override();
      @(posedge i_ref_clk);
      i_cap_load <= 1'b1;
      i_cap_data <= '{port_num: 8'h05, l1_lat: 3'h5, l0s_lat: 3'h6, aspm: 2'h3, speed: 4'h1};
      @(posedge i_ref_clk);
      i_cap_load <= 1'b0;
      bus_rd("caps_load", port_regs_pkg::OFS_LINK_CAPABILITIES, 32'h0532_EC11);
   endtask
   // Mid-run reset must drop flags and loaded capabilities
   task automatic t_mid_reset();
      @(posedge i_ref_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      bus_rd("st_reset", port_regs_pkg::OFS_DEVICE_STATUS, ST_IDLE);
      bus_rd("caps_reset", port_regs_pkg::OFS_LINK_CAPABILITIES, 32'h0230_3012);
      chk("irq_reset", 32'h0, {31'h0, o_irq});
   endtask
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      t_reset_values();
      t_error_flags();
      t_set_beats_clear();
      t_interrupt();
      t_cap_override();
      t_mid_reset();
      stop_test();
   end
endmodule
